// ---- tmc_pkg.sv ----
// Shared constants, types and CRC helpers for the tag memory command handler.
package tmc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_TIME_NS = 250000;
  localparam int HALF_BIT_CYC = BIT_TIME_NS / 2 / CLK_PERIOD_NS;
  localparam int WRESP_TIME_NS = 200000;
  localparam int WRESP_CYC = WRESP_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Frame layout and command codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_BITS = 6'h14;
  localparam logic [5:0] DATA_BITS = 6'h28;
  localparam logic [3:0] CMD_READ_PAGE = 4'hc;
  localparam logic [3:0] CMD_READ_BLOCK = 4'hd;
  localparam logic [3:0] CMD_WRITE_PAGE = 4'h8;
  localparam logic [3:0] CMD_WRITE_BLOCK = 4'h9;
  localparam logic [3:0] CMD_QUIET = 4'h7;
  localparam logic [1:0] ACK_CODE = 2'h1;
  localparam logic [2:0] SOF_PAT = 3'h7;
  localparam logic [4:0] SOF_LEN = 5'h03;
  localparam logic [1:0] BLOCK_LAST = 2'h3;
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam int PAGES = 64;
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 8;

  typedef enum logic [2:0] {
    TMC_CMD, TMC_WRESP, TMC_PUSH, TMC_WDATA, TMC_PROG
  } tmc_state_t;

  // ----------------------------------------------------------------
  // CRC helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] tmc_crc_bit(input logic [7:0] crc, input logic b);
    tmc_crc_bit = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] tmc_crc_byte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = tmc_crc_bit(c, d[i]);
    end
    tmc_crc_byte = c;
  endfunction

endpackage

// ---- tmc_handler.sv ----
// Reply FIFO and memory command handler of a contactless tag.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Reads are served only when selected, and authenticated if auth mode is on.
// - Code 1100 returns start-of-frame then the 32 bits of the addressed page.
// - Command is code, 8-bit page address, 8-bit CRC, then end of frame.
// - Highest page is 0x3f; the two top address bits are zero.
// - Code 1101 returns pages from the addressed one to the block's last.
// - Multi-byte values travel least significant byte first.
// - Writes are served only when selected, and authenticated if auth mode is on.
// - A good code 1000 is answered with start-of-frame and acknowledge 01.
// - After programming time the tag answers start-of-frame and acknowledge.
// - A good code 1001 is answered with start-of-frame and acknowledge.
// - Each page of a block write is programmed and acknowledged on its own.
// - Code 0111 makes the tag quiet and it answers start-of-frame and 01.
// - A quiet tag answers nothing until the field goes away.
// - Start-of-frame and acknowledge are sent Manchester coded.
// - Loss of field returns the tag to power-off from any state.

// ------------------------------------------------------------------
// Reply FIFO
// ------------------------------------------------------------------
module tmc_fifo #(parameter int WIDTH = 10, parameter int DEPTH = 8) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = cnt_q != (AW + 1)'(DEPTH);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data = mem_q[rd_q];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
      rd_q <= pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// Command handler
// ------------------------------------------------------------------
module tmc_handler #(
  parameter int unsigned P_HALF_BIT_CYC = tmc_pkg::HALF_BIT_CYC,
  parameter int unsigned P_WRESP_CYC = tmc_pkg::WRESP_CYC,
  parameter int unsigned P_PROG_CYC = tmc_pkg::PROG_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_selected,
  input wire logic i_auth_mode,
  input wire logic i_authenticated,
  input wire logic i_rx_valid,
  input wire logic i_rx_bit,
  input wire logic i_rx_eof,
  output logic o_tx_mod,
  output logic o_tx_active,
  output logic o_quiet,
  output logic o_busy
);
  import tmc_pkg::*;

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  tmc_state_t st_q;
  logic [39:0] rx_sr_q;
  logic [7:0] rx_crc_q;
  logic [5:0] rx_cnt_q;
  logic quiet_q;
  logic [31:0] mem_q [PAGES];

  wire rx_on = (st_q == TMC_CMD && !quiet_q) || st_q == TMC_WDATA;
  wire [3:0] cmd_code = rx_sr_q[19:16];
  wire [5:0] cmd_page = rx_sr_q[13:8];
  wire crc_good = rx_crc_q == 8'h00;
  wire authorized = i_selected && (!i_auth_mode || i_authenticated);
  wire known = cmd_code == CMD_READ_PAGE || cmd_code == CMD_READ_BLOCK || cmd_code == CMD_QUIET
    || cmd_code == CMD_WRITE_PAGE || cmd_code == CMD_WRITE_BLOCK;
  wire cmd_eof = rx_on && st_q == TMC_CMD && i_rx_eof;
  wire go = cmd_eof && rx_cnt_q == CMD_BITS && crc_good && rx_sr_q[15:14] == 2'h0
    && authorized && known;
  wire data_ok = st_q == TMC_WDATA && i_rx_eof && rx_cnt_q == DATA_BITS && crc_good;
  wire data_bad = st_q == TMC_WDATA && i_rx_eof && !data_ok;
  // first byte received is the low byte
  wire [31:0] rx_word = {rx_sr_q[15:8], rx_sr_q[23:16], rx_sr_q[31:24], rx_sr_q[39:32]};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_sr_q <= '0;
      rx_crc_q <= CRC_INIT;
      rx_cnt_q <= '0;
    end else if (i_rx_eof) begin
      rx_crc_q <= CRC_INIT;
      rx_cnt_q <= '0;
    end else if (i_rx_valid && rx_on) begin
      rx_sr_q <= {rx_sr_q[38:0], i_rx_bit};
      rx_crc_q <= tmc_crc_bit(rx_crc_q, i_rx_bit);
      rx_cnt_q <= (rx_cnt_q == 6'h3f) ? rx_cnt_q : rx_cnt_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [3:0] op_q;
  logic [5:0] page_q;
  logic [1:0] byte_q;
  logic [19:0] timer_q;
  logic ack_only_q;
  logic phase_q;
  logic [31:0] wdata_q;
  logic fifo_in_ready;

  wire [31:0] rd_word = mem_q[page_q];
  wire is_rblk = op_q == CMD_READ_BLOCK;
  wire is_wblk = op_q == CMD_WRITE_BLOCK;
  wire is_write = op_q == CMD_WRITE_PAGE || is_wblk;
  wire blk_end = page_q[1:0] == BLOCK_LAST;
  // block read ends on the block's last page
  wire push_last = ack_only_q || (byte_q == 2'h3 && (!is_rblk || blk_end));
  wire push = st_q == TMC_PUSH && fifo_in_ready;
  wire [7:0] push_byte = ack_only_q ? 8'h00 : rd_word[8 * byte_q +: 8];
  wire prog_now = st_q == TMC_PROG && timer_q == 20'h0;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= TMC_CMD;
      op_q <= '0;
      page_q <= '0;
      byte_q <= '0;
      timer_q <= '0;
      ack_only_q <= 1'b0;
      phase_q <= 1'b0;
      wdata_q <= '0;
      quiet_q <= 1'b0;
    end else begin
      case (st_q)
        TMC_CMD: begin
          if (go) begin
            op_q <= cmd_code;
            page_q <= cmd_page;
            byte_q <= 2'h0;
            ack_only_q <= cmd_code != CMD_READ_PAGE && cmd_code != CMD_READ_BLOCK;
            phase_q <= 1'b0;
            timer_q <= 20'(P_WRESP_CYC - 1);
            st_q <= TMC_WRESP;
          end
        end
        TMC_WRESP: begin
          timer_q <= timer_q - 20'h1;
          if (timer_q == 20'h0) begin
            st_q <= TMC_PUSH;
          end
        end
        TMC_PUSH: begin
          if (push && !push_last) begin
            byte_q <= byte_q + 2'h1;
            page_q <= (byte_q == 2'h3) ? page_q + 6'h01 : page_q;
          end else if (push) begin
            byte_q <= 2'h0;
            // quiet takes hold with its acknowledge
            quiet_q <= quiet_q || op_q == CMD_QUIET;
            phase_q <= 1'b1;
            if (is_write && !phase_q) begin
              st_q <= TMC_WDATA;
            end else if (is_wblk && !blk_end) begin
              page_q <= page_q + 6'h01;
              st_q <= TMC_WDATA;
            end else begin
              st_q <= TMC_CMD;
            end
          end
        end
        TMC_WDATA: begin
          if (data_ok) begin
            wdata_q <= rx_word;
            timer_q <= 20'(P_PROG_CYC - 1);
            st_q <= TMC_PROG;
          end else if (data_bad) begin
            st_q <= TMC_CMD;
          end
        end
        TMC_PROG: begin
          timer_q <= timer_q - 20'h1;
          if (timer_q == 20'h0) begin
            st_q <= TMC_PUSH;
          end
        end
        default: st_q <= TMC_CMD;
      endcase
    end
  end

  // Page storage is non-volatile, so field loss leaves it alone.
  always_ff @(posedge i_ref_clk) begin
    if (prog_now) begin
      mem_q[page_q] <= wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // Reply FIFO and Manchester transmitter
  // ----------------------------------------------------------------
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [18:0] tx_sr_q;
  logic [4:0] tx_n_q;
  logic [15:0] tx_cnt_q;
  logic [7:0] tx_crc_q;
  logic tx_infr_q;

  wire tx_pop = tx_n_q == 5'h0 && fifo_out_valid;
  wire e_last = fifo_out_data[9];
  wire e_ack = fifo_out_data[8];
  wire [7:0] e_byte = fifo_out_data[7:0];
  wire [7:0] crc_after = tmc_crc_byte(tx_infr_q ? tx_crc_q : CRC_INIT, e_byte);
  // acknowledge is the pair 0 then 1
  wire [18:0] body = e_ack ? {ACK_CODE, 17'h0}
    : (e_last ? {e_byte, crc_after, 3'h0} : {e_byte, 11'h0});
  wire [4:0] body_n = e_ack ? 5'h02 : (e_last ? 5'h10 : 5'h08);
  // every reply frame opens with the start pattern
  wire [18:0] vec = tx_infr_q ? body : {SOF_PAT, body[18:3]};
  wire [4:0] vec_n = tx_infr_q ? body_n : body_n + SOF_LEN;
  wire [15:0] bit_top = 16'(2 * P_HALF_BIT_CYC - 1);
  wire bit_done = tx_cnt_q == 16'h0;
  wire [18:0] tx_sr_d = tx_pop ? vec : (bit_done ? {tx_sr_q[17:0], 1'b0} : tx_sr_q);
  wire [4:0] tx_n_d = tx_pop ? vec_n : ((tx_n_q != 5'h0 && bit_done) ? tx_n_q - 5'h1 : tx_n_q);
  wire [15:0] tx_cnt_d = (tx_pop || bit_done) ? bit_top : tx_cnt_q - 16'h1;
  // first half carries the bit, second half its inverse
  wire first_half = tx_cnt_d >= 16'(P_HALF_BIT_CYC);
  wire tx_mod_d = tx_n_d != 5'h0 && (first_half ? tx_sr_d[18] : !tx_sr_d[18]);

  tmc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(st_q == TMC_PUSH),
    .o_in_ready(fifo_in_ready),
    .i_in_data({push_last, ack_only_q, push_byte}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(tx_n_q == 5'h0),
    .o_out_data(fifo_out_data)
  );
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_sr_q <= '0;
      tx_n_q <= '0;
      tx_cnt_q <= '0;
      tx_crc_q <= CRC_INIT;
      tx_infr_q <= 1'b0;
      o_tx_mod <= 1'b0;
      o_tx_active <= 1'b0;
      o_quiet <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      tx_sr_q <= tx_sr_d;
      tx_n_q <= tx_n_d;
      tx_cnt_q <= tx_cnt_d;
      tx_crc_q <= tx_pop ? crc_after : tx_crc_q;
      tx_infr_q <= tx_pop ? !e_last : tx_infr_q;
      o_tx_mod <= tx_mod_d;
      o_tx_active <= tx_n_d != 5'h0;
      o_quiet <= quiet_q;
      o_busy <= st_q != TMC_CMD;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  quiet_silent_a: assert property (quiet_q && st_q == TMC_CMD |=> st_q == TMC_CMD)
    else $error("Quiet tag left command wait.");
  crc_reject_a: assert property (cmd_eof && !crc_good |=> st_q == TMC_CMD)
    else $error("Command with bad CRC was accepted.");
  addr_reject_a: assert property (cmd_eof && rx_sr_q[15:14] != 2'h0 |=> st_q == TMC_CMD)
    else $error("Command with high address bits was accepted.");
  unauth_reject_a: assert property (cmd_eof && !authorized |=> st_q == TMC_CMD)
    else $error("Unselected tag accepted a memory command.");
  quiet_entry_a: assert property (push && op_q == CMD_QUIET |=> quiet_q ##1 o_quiet)
    else $error("Quiet acknowledge did not enter quiet state.");
  prog_store_a: assert property (prog_now |=> st_q == TMC_PUSH
      && mem_q[$past(page_q)] == $past(wdata_q))
    else $error("Page not programmed before acknowledge.");
  bad_data_a: assert property (data_bad |=> st_q == TMC_CMD ##1 st_q != TMC_PROG)
    else $error("Bad data frame led to programming.");
  block_end_a: assert property (push && push_last && is_rblk |-> page_q[1:0] == 2'h3)
    else $error("Block read ended before the block's last page.");
  mid_bit_a: assert property (o_tx_active && tx_cnt_q == 16'(P_HALF_BIT_CYC)
      |=> o_tx_mod != $past(o_tx_mod))
    else $error("No mid-bit transition in Manchester output.");
  idle_low_a: assert property (!o_tx_active |-> !o_tx_mod)
    else $error("Modulation while transmitter idle.");
  read_page_c: cover property (go && cmd_code == CMD_READ_PAGE);
  read_block_c: cover property (push && push_last && is_rblk && byte_q == 2'h3);
  write_block_c: cover property (prog_now && is_wblk && blk_end);
  quiet_c: cover property (push && op_q == CMD_QUIET);
endmodule

`default_nettype wire

// ---- tmc_reader.sv ----
// Reader/writer device model: sends command and data frames, decodes replies.
`timescale 1ns/1ns
`default_nettype none
module tmc_reader #(
  parameter int HB = 4,
  parameter int SETUP = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_tx_mod,
  input wire logic i_tx_active,
  output logic o_rx_valid,
  output logic o_rx_bit,
  output logic o_rx_eof
);
  import tmc_pkg::*;
  logic rx_q[$];
  int code_err = 0;
  int cnt = 0;
  logic first = 1'b0;
  logic act_d = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_bit = 1'b0;
    o_rx_eof = 1'b0;
  end
  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c0, input logic [31:0] f, input int n);
    logic [7:0] c;
    c = c0;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? CRC_POLY : 8'h00);
    crc8 = c;
  endfunction
  task automatic send(input logic [47:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge i_ref_clk);
      #1;
      o_rx_valid = 1'b1;
      o_rx_bit = f[i];
    end
    @(posedge i_ref_clk);
    #1;
    o_rx_valid = 1'b0;
    // The line is released, so it shows the inverse of its last bit.
    o_rx_bit = ~o_rx_bit;
    o_rx_eof = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_rx_eof = 1'b0;
  endtask
  task automatic send_data(input logic [31:0] w, input logic flip);
    logic [31:0] b;
    b = {w[7:0], w[15:8], w[23:16], w[31:24]};
    repeat (SETUP) @(posedge i_ref_clk);
    send({8'h00, b, crc8(CRC_INIT, b, 32) ^ {7'h00, flip}}, 40);
  endtask
  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  // Manchester decode
  always @(posedge i_ref_clk) begin
    act_d <= i_tx_active;
    if (!i_tx_active) begin
      cnt <= 0;
      if (!act_d && i_tx_mod) code_err <= code_err + 1;
    end else begin
      cnt <= (cnt == 2 * HB - 1) ? 0 : cnt + 1;
      if (cnt == 1) first <= i_tx_mod;
      if (cnt == HB + 1) begin
        if (first == i_tx_mod) code_err <= code_err + 1;
        rx_q.push_back(first);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tmc_handler_bench.sv ----
// Self-checking bench for the tag memory command handler.
`timescale 1ns/1ns
`default_nettype none
module tmc_handler_bench;
  import tmc_pkg::*;
  localparam int HB = 4;
  localparam int LIMIT = 40000;
  localparam logic [159:0] ACK_EXP = 160'({SOF_PAT, ACK_CODE});
  typedef struct {
    logic [3:0] code;
    logic [7:0] addr;
    logic [31:0] word;
    logic [2:0] perm;
    logic ok;
  } tmc_row_t;
  logic ref_clk;
  logic rst = 1'b1;
  logic selected = 1'b1;
  logic auth_mode = 1'b0;
  logic authenticated = 1'b0;
  logic rx_valid;
  logic rx_bit;
  logic rx_eof;
  logic tx_mod;
  logic tx_active;
  logic quiet;
  logic busy;
  logic [31:0] mem [64];
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // Permission bits are {selected, auth mode, authenticated}.
  tmc_row_t rows[12] = '{
    '{CMD_WRITE_PAGE, 8'h05, 32'h11223344, 3'h4, 1'b1},
    '{CMD_READ_PAGE, 8'h05, 32'h0, 3'h4, 1'b1},
    '{CMD_READ_PAGE, 8'h05, 32'h0, 3'h0, 1'b0},
    '{CMD_WRITE_PAGE, 8'h06, 32'h5, 3'h6, 1'b0},
    '{CMD_WRITE_PAGE, 8'h06, 32'ha5c3e1f0, 3'h7, 1'b1},
    '{CMD_READ_PAGE, 8'h46, 32'h0, 3'h4, 1'b0},
    '{CMD_WRITE_BLOCK, 8'h3c, 32'hdeadbe00, 3'h4, 1'b1},
    '{CMD_READ_BLOCK, 8'h3e, 32'h0, 3'h4, 1'b1},
    '{CMD_READ_BLOCK, 8'h3c, 32'h0, 3'h4, 1'b1},
    '{CMD_READ_BLOCK, 8'h3f, 32'h0, 3'h4, 1'b1},
    '{4'h3, 8'h05, 32'h0, 3'h4, 1'b0},
    '{CMD_READ_PAGE, 8'h06, 32'h0, 3'h7, 1'b1}
  };
  tmc_handler #(.P_HALF_BIT_CYC(HB), .P_WRESP_CYC(5), .P_PROG_CYC(20)) i_dut (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_selected(selected), .i_auth_mode(auth_mode),
    .i_authenticated(authenticated), .i_rx_valid(rx_valid), .i_rx_bit(rx_bit),
    .i_rx_eof(rx_eof), .o_tx_mod(tx_mod), .o_tx_active(tx_active), .o_quiet(quiet),
    .o_busy(busy));
  tmc_reader #(.HB(HB)) i_rdr (
    .i_ref_clk(ref_clk), .i_tx_mod(tx_mod), .i_tx_active(tx_active),
    .o_rx_valid(rx_valid), .o_rx_bit(rx_bit), .o_rx_eof(rx_eof));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [159:0] got, input logic [159:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [7:0] a, input logic flip);
    logic [11:0] h;
    h = {c, a};
    i_rdr.send({28'h0, h, i_rdr.crc8(CRC_INIT, {20'h0, h}, 12) ^ {7'h00, flip}}, 20);
  endtask
  // An empty reply is awaited long enough for a reply to have shown up.
  task automatic expect_reply(input logic [159:0] exp, input int n);
    logic [159:0] got;
    got = '0;
    for (int k = 0; k < 3000 && i_rdr.rx_q.size() < n; k++) @(posedge ref_clk);
    repeat (n == 0 ? 60 : 4 * HB) @(posedge ref_clk);
    #1;
    check(160'(i_rdr.rx_q.size()), 160'(n));
    for (int i = 0; i < i_rdr.rx_q.size(); i++) got = {got[158:0], i_rdr.rx_q[i]};
    i_rdr.rx_q.delete();
    check(got, exp);
    if (n == 0) check(160'(busy), 160'(0));
  endtask
  task automatic run_row(input tmc_row_t r);
    int np;
    logic [31:0] w;
    logic [7:0] c;
    logic [159:0] e;
    @(posedge ref_clk);
    #1;
    {selected, auth_mode, authenticated} = r.perm;
    np = (r.code == CMD_READ_BLOCK || r.code == CMD_WRITE_BLOCK) ? 4 - r.addr[1:0] : 1;
    cmd(r.code, r.addr, 1'b0);
    if (!r.ok) begin
      expect_reply('0, 0);
    end else if (r.code[3:2] == 2'b10) begin
      expect_reply(ACK_EXP, 5);
      check(160'(busy), 160'(1));
      for (int p = 0; p < np; p++) begin
        i_rdr.send_data(r.word + 32'(p), 1'b0);
        mem[r.addr[5:0] + 6'(p)] = r.word + 32'(p);
        expect_reply(ACK_EXP, 5);
      end
    end else begin
      e = 160'(SOF_PAT);
      c = CRC_INIT;
      for (int p = 0; p < np; p++) begin
        w = mem[r.addr[5:0] + 6'(p)];
        w = {w[7:0], w[15:8], w[23:16], w[31:24]};
        e = {e[127:0], w};
        c = i_rdr.crc8(c, w, 32);
      end
      expect_reply({e[151:0], c}, 11 + 32 * np);
    end
  endtask
  task automatic pulse_reset;
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    #2;
    check(160'({tx_active, tx_mod, quiet, busy}), 160'(0));
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    i_rdr.rx_q.delete();
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and scenarios
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    cmd(CMD_READ_PAGE, 8'h05, 1'b1);
    expect_reply('0, 0);
    cmd(CMD_WRITE_PAGE, 8'h05, 1'b0);
    expect_reply(ACK_EXP, 5);
    i_rdr.send_data(32'h99887766, 1'b1);
    expect_reply('0, 0);
    // A refused data frame must leave the old page contents in place.
    run_row('{CMD_READ_PAGE, 8'h05, 32'h0, 3'h4, 1'b1});
    cmd(CMD_QUIET, 8'h00, 1'b0);
    expect_reply(ACK_EXP, 5);
    check(160'(quiet), 160'(1));
    cmd(CMD_READ_PAGE, 8'h05, 1'b0);
    expect_reply('0, 0);
    pulse_reset;
    cmd(CMD_READ_PAGE, 8'h06, 1'b0);
    for (int k = 0; k < 200 && tx_active !== 1'b1; k++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    pulse_reset;
    run_row('{CMD_READ_PAGE, 8'h06, 32'h0, 3'h4, 1'b1});
    check(160'(i_rdr.code_err), 160'(0));
    end_of_test;
  end
endmodule
`default_nettype wire
